// [src/dwb_cfg.svh]
`ifndef DWB_CFG_SVH
`define DWB_CFG_SVH

// Register byte offsets
`define DWB_ADDR_MODE 8'h00
`define DWB_ADDR_LAT 8'h04
`define DWB_ADDR_TIMING 8'h08
`define DWB_ADDR_STATUS 8'h0C
`define DWB_ADDR_COUNT 8'h10

// Field positions
`define DWB_LAT_CWL_LSB 8
`define DWB_STAT_FLAG_LSB 16
`define DWB_STAT_BUSY_BIT 19
`define DWB_FLAG_WTR 0
`define DWB_FLAG_PRE 1
`define DWB_FLAG_OVF 2

// Timing, clock at 5 ns
`define DWB_CLK_PERIOD_NS 5
`define DWB_WTR_S_NS 10
`define DWB_WTR_L_NS 20
`define DWB_ACTIVATE_TO_PRECHARGE_MIN_NS 32
`define DWB_WTR_S_CYC ((`DWB_WTR_S_NS + `DWB_CLK_PERIOD_NS - 1) / `DWB_CLK_PERIOD_NS)
`define DWB_WTR_L_CYC ((`DWB_WTR_L_NS + `DWB_CLK_PERIOD_NS - 1) / `DWB_CLK_PERIOD_NS)
`define DWB_ACTIVATE_TO_PRECHARGE_MIN_CYC ((`DWB_ACTIVATE_TO_PRECHARGE_MIN_NS + `DWB_CLK_PERIOD_NS - 1) / `DWB_CLK_PERIOD_NS)

// Reset values
`define DWB_RST_MODE 2'h0
`define DWB_RST_AL 5'h00
`define DWB_RST_CWL 5'h09
`define DWB_RST_WR 8'h0C

`endif

// [src/dwb_pkg.sv]
package dwb_pkg;

  typedef enum logic [1:0] {
    BL_FIXED8 = 2'b00,
    BL_OTF = 2'b01,
    BL_CHOP4 = 2'b10,
    BL_RSVD = 2'b11
  } dwb_blmode_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_ACT = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_READ = 3'b011,
    CMD_PRE = 3'b100
  } dwb_cmd_t;

  typedef enum logic {
    BS_IDLE = 1'b0,
    BS_DATA = 1'b1
  } dwb_bstate_t;

endpackage : dwb_pkg

// [src/dwb_fifo.sv]
module dwb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // Depth must be a power of two so pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic outValid_q;
  logic [WIDTH-1:0] outData_q;
  logic push;
  logic load;

  assign inReady = count_q != CW'(DEPTH);
  assign push = inValid && inReady;
  // Refill the output register whenever it is empty or being drained
  assign load = (count_q != '0) && (!outValid_q || outReady);
  assign outValid = outValid_q;
  assign outData = outData_q;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + AW'(1);
      end
      if (load) begin
        rdPtr_q <= rdPtr_q + AW'(1);
      end
      count_q <= count_q + CW'(push) - CW'(load);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outValid_q <= 1'b0;
      outData_q <= '0;
    end else if (load) begin
      outValid_q <= 1'b1;
      outData_q <= mem_q[rdPtr_q];
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end

endmodule : dwb_fifo

// [src/dwb_write_engine.sv]
`include "dwb_cfg.svh"
module dwb_write_engine #(
  parameter int DQ_W = 8,
  parameter int COL_W = 10,
  parameter int FIFO_DEPTH = 16,
  parameter int LINE_DEPTH = 64,
  localparam int WORD_W = 4 + COL_W + 2 * DQ_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmdValid,
  input wire dwb_pkg::dwb_cmd_t cmdKind,
  input wire logic [1:0] cmdBankGroup,
  input wire logic [1:0] cmdBank,
  input wire logic [COL_W-1:0] cmdColumn,
  input wire logic chopSelectAddressBit,
  input wire logic autoprechargeAddressBit,
  input wire logic [2*DQ_W-1:0] writeData,
  output logic dataReady,
  output logic coreValid,
  input wire logic coreReady,
  output logic [WORD_W-1:0] coreWord,
  output logic [15:0] bankOpen
);
  import dwb_pkg::*;

  localparam int ENTRY_W = COL_W + 8;
  localparam int E_BANK = COL_W;
  localparam int E_CLOSE = COL_W + 4;
  localparam int E_FIXED = COL_W + 5;
  localparam int E_CHOP = COL_W + 6;
  localparam int E_VALID = COL_W + 7;

  dwb_blmode_t burstMode_q;
  logic [4:0] addLat_q;
  logic [4:0] colWriteLat_q;
  logic [7:0] wrRecov_q;
  logic [7:0] wtrShortSet_q;
  logic [7:0] wtrLongSet_q;
  logic [7:0] rasMin_q;
  logic [2:0] flags_q;
  logic [15:0] burstCount_q;
  logic [31:0] rdMux;
  logic [31:0] merged;
  logic wbWrite;
  logic wbStart;

  logic [ENTRY_W-1:0] line_q [LINE_DEPTH];
  logic [ENTRY_W-1:0] tap;
  logic [5:0] writeLat;
  logic [5:0] wlTap;
  logic lineBusy;
  logic lineHitsBank;

  dwb_bstate_t burstState_q;
  logic [1:0] beatIdx_q;
  logic curChop_q;
  logic curFixed_q;
  logic curClose_q;
  logic [3:0] curBank_q;
  logic [COL_W-1:0] curCol_q;
  logic fire;
  logic capture;
  logic [1:0] effIdx;
  logic effChop;
  logic effFixed;
  logic [3:0] effBank;
  logic [COL_W-1:0] effCol;
  logic storeBeat;
  logic lastBeat;
  logic lastSeen_q;
  logic [3:0] lastBank_q;
  logic lastClose_q;
  logic lastFixed_q;

  logic [7:0] recov_q [16];
  logic [7:0] ras_q [16];
  logic [15:0] closePend_q;
  logic [15:0] bankOpen_q;
  logic [15:0] autoCloseNow;
  logic [7:0] wtrS_q;
  logic [7:0] wtrL_q;
  logic [1:0] wtrGroup_q;
  logic dataReady_q;

  logic isAct;
  logic isWrite;
  logic isRead;
  logic isPre;
  logic [3:0] cmdBankId;
  logic cmdChop;
  logic writeInFlight;
  logic readEarly;
  logic preEarly;
  logic pushReady;
  logic [2:0] flagSet;
  logic [2:0] flagClr;

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = newV[8*i +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // Wishbone: ack one cycle after the strobe, write lands on the ack edge
  assign wbStart = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign merged = mergeBytes(rdMux, wb_dat_i, wb_sel_i);

  always_comb begin
    rdMux = 32'h0000_0000;
    case (wb_adr_i)
      `DWB_ADDR_MODE: rdMux[1:0] = burstMode_q;
      `DWB_ADDR_LAT: begin
        rdMux[4:0] = addLat_q;
        rdMux[`DWB_LAT_CWL_LSB +: 5] = colWriteLat_q;
      end
      `DWB_ADDR_TIMING: rdMux = {rasMin_q, wtrLongSet_q, wtrShortSet_q, wrRecov_q};
      `DWB_ADDR_STATUS: begin
        rdMux[15:0] = bankOpen_q;
        rdMux[`DWB_STAT_FLAG_LSB +: 3] = flags_q;
        rdMux[`DWB_STAT_BUSY_BIT] = writeInFlight;
      end
      `DWB_ADDR_COUNT: rdMux[15:0] = burstCount_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbStart;
      if (wbStart) begin
        wb_dat_o <= rdMux;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      burstMode_q <= dwb_blmode_t'(`DWB_RST_MODE);
      addLat_q <= `DWB_RST_AL;
      colWriteLat_q <= `DWB_RST_CWL;
      wrRecov_q <= `DWB_RST_WR;
      wtrShortSet_q <= 8'(`DWB_WTR_S_CYC);
      wtrLongSet_q <= 8'(`DWB_WTR_L_CYC);
      rasMin_q <= 8'(`DWB_ACTIVATE_TO_PRECHARGE_MIN_CYC);
    end else if (wbWrite) begin
      case (wb_adr_i)
        `DWB_ADDR_MODE: burstMode_q <= dwb_blmode_t'(merged[1:0]);
        `DWB_ADDR_LAT: begin
          addLat_q <= merged[4:0];
          colWriteLat_q <= merged[`DWB_LAT_CWL_LSB +: 5];
        end
        `DWB_ADDR_TIMING: {rasMin_q, wtrLongSet_q, wtrShortSet_q, wrRecov_q} <= merged;
        default: ;
      endcase
    end
  end

  // Status flags are write-one-to-clear; a new event beats the clear
  assign flagClr = (wbWrite && wb_adr_i == `DWB_ADDR_STATUS && wb_sel_i[2]) ?
                   wb_dat_i[`DWB_STAT_FLAG_LSB +: 3] : 3'h0;
  assign flagSet = {storeBeat && !pushReady, preEarly, readEarly};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~flagClr) | flagSet;
    end
  end

  assign isAct = cmdValid && cmdKind == CMD_ACT;
  assign isWrite = cmdValid && cmdKind == CMD_WRITE;
  assign isRead = cmdValid && cmdKind == CMD_READ;
  assign isPre = cmdValid && cmdKind == CMD_PRE;
  assign cmdBankId = {cmdBankGroup, cmdBank};

  always_comb begin
    unique case (burstMode_q)
      BL_CHOP4: cmdChop = 1'b1;
      BL_OTF: cmdChop = !chopSelectAddressBit;
      default: cmdChop = 1'b0;
    endcase
  end

  // Command delay line; the tap sits at write latency
  assign writeLat = 6'(addLat_q) + 6'(colWriteLat_q);
  assign wlTap = (writeLat == 6'h00) ? 6'h00 : writeLat - 6'h01;
  assign tap = line_q[wlTap];
  assign fire = tap[E_VALID];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LINE_DEPTH; i++) begin
        line_q[i] <= '0;
      end
    end else begin
      line_q[0] <= isWrite ? {1'b1, cmdChop, burstMode_q == BL_CHOP4, autoprechargeAddressBit,
                              cmdBankId, cmdColumn} : '0;
      for (int i = 1; i < LINE_DEPTH; i++) begin
        line_q[i] <= line_q[i-1];
      end
    end
  end

  always_comb begin
    lineBusy = 1'b0;
    lineHitsBank = 1'b0;
    // Entries past the tap were captured already and no longer count as pending
    for (int i = 0; i < LINE_DEPTH; i++) begin
      if (i <= int'(wlTap)) begin
        lineBusy = lineBusy | line_q[i][E_VALID];
        lineHitsBank = lineHitsBank |
                       (line_q[i][E_VALID] && line_q[i][E_BANK +: 4] == cmdBankId);
      end
    end
  end

  // A new burst at the tap overrides any tail still running
  assign capture = fire || burstState_q == BS_DATA;
  assign effIdx = fire ? 2'h0 : beatIdx_q;
  assign effChop = fire ? tap[E_CHOP] : curChop_q;
  assign effFixed = fire ? tap[E_FIXED] : curFixed_q;
  assign effBank = fire ? tap[E_BANK +: 4] : curBank_q;
  assign effCol = fire ? tap[COL_W-1:0] : curCol_q;
  // Chopped bursts keep the first two clocks of data only
  assign storeBeat = capture && !(effChop && effIdx[1]);
  // Per-command chop still holds the bus four clocks, fixed chop two
  assign lastBeat = capture && effIdx == (effFixed ? 2'h1 : 2'h3);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      burstState_q <= BS_IDLE;
      beatIdx_q <= 2'h0;
      curChop_q <= 1'b0;
      curFixed_q <= 1'b0;
      curClose_q <= 1'b0;
      curBank_q <= 4'h0;
      curCol_q <= '0;
    end else if (capture) begin
      burstState_q <= lastBeat ? BS_IDLE : BS_DATA;
      beatIdx_q <= effIdx + 2'h1;
      if (fire) begin
        curChop_q <= tap[E_CHOP];
        curFixed_q <= tap[E_FIXED];
        curClose_q <= tap[E_CLOSE];
        curBank_q <= tap[E_BANK +: 4];
        curCol_q <= tap[COL_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastSeen_q <= 1'b0;
      lastBank_q <= 4'h0;
      lastClose_q <= 1'b0;
      lastFixed_q <= 1'b0;
      burstCount_q <= 16'h0000;
    end else begin
      lastSeen_q <= lastBeat;
      if (lastBeat) begin
        lastBank_q <= effBank;
        lastClose_q <= fire ? tap[E_CLOSE] : curClose_q;
        lastFixed_q <= effFixed;
      end
      if (lastSeen_q) begin
        burstCount_q <= burstCount_q + 16'h0001;
      end
    end
  end

  dwb_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .inValid(storeBeat),
    .inReady(pushReady),
    .inData({effBank, effCol + COL_W'({effIdx, 1'b0}), writeData}),
    .outValid(coreValid),
    .outReady(coreReady),
    .outData(coreWord)
  );

  // Recovery and write-to-read load one edge after the edge that captures the last data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wtrS_q <= 8'h00;
      wtrL_q <= 8'h00;
      wtrGroup_q <= 2'h0;
    end else if (lastSeen_q) begin
      wtrS_q <= wtrShortSet_q;
      wtrL_q <= wtrLongSet_q;
      wtrGroup_q <= lastBank_q[3:2];
    end else begin
      wtrS_q <= (wtrS_q != 8'h00) ? wtrS_q - 8'h01 : 8'h00;
      wtrL_q <= (wtrL_q != 8'h00) ? wtrL_q - 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < 16; b++) begin
        recov_q[b] <= 8'h00;
        ras_q[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (lastSeen_q && lastBank_q == 4'(b)) begin
          recov_q[b] <= wrRecov_q;
        end else if (recov_q[b] != 8'h00) begin
          recov_q[b] <= recov_q[b] - 8'h01;
        end
        if (isAct && cmdBankId == 4'(b)) begin
          ras_q[b] <= rasMin_q;
        end else if (ras_q[b] != 8'h00) begin
          ras_q[b] <= ras_q[b] - 8'h01;
        end
      end
    end
  end

  // Internal close waits for recovery and the activate-to-precharge minimum
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      autoCloseNow[b] = closePend_q[b] && recov_q[b] < 8'h02 && ras_q[b] < 8'h02 &&
                        !(lastSeen_q && lastBank_q == 4'(b));
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      closePend_q <= 16'h0000;
      bankOpen_q <= 16'h0000;
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (lastSeen_q && lastClose_q && lastBank_q == 4'(b)) begin
          closePend_q[b] <= 1'b1;
        end else if (autoCloseNow[b] || (isPre && cmdBankId == 4'(b))) begin
          closePend_q[b] <= 1'b0;
        end
        if (isAct && cmdBankId == 4'(b)) begin
          bankOpen_q[b] <= 1'b1;
        end else if (autoCloseNow[b] || (isPre && cmdBankId == 4'(b))) begin
          bankOpen_q[b] <= 1'b0;
        end
      end
    end
  end

  // Controller spacing is its own duty; breaches are only recorded
  assign writeInFlight = lineBusy || burstState_q == BS_DATA || lastSeen_q;
  // A counter at one expires on this very edge, so a command here is already legal
  assign readEarly = isRead && (writeInFlight ||
                     (cmdBankGroup == wtrGroup_q ? wtrL_q > 8'h01 : wtrS_q > 8'h01));
  assign preEarly = isPre && (recov_q[cmdBankId] > 8'h01 || ras_q[cmdBankId] > 8'h01 ||
                    lineHitsBank || (burstState_q == BS_DATA && curBank_q == cmdBankId) ||
                    (lastSeen_q && lastBank_q == cmdBankId));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataReady_q <= 1'b0;
    end else begin
      dataReady_q <= pushReady;
    end
  end

  assign dataReady = dataReady_q;
  assign bankOpen = bankOpen_q;

endmodule : dwb_write_engine

// [test/dwb_write_engine_asserts.sv]
module dwb_checker #(
  parameter int DQ_W = 8,
  parameter int COL_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cmdValid,
  input wire dwb_pkg::dwb_cmd_t cmdKind,
  input wire logic coreValid,
  input wire logic coreReady,
  input wire logic [4+COL_W+2*DQ_W-1:0] coreWord
);
  timeunit 1ns;
  timeprecision 100ps;
  import dwb_pkg::*;
  logic [5:0] wlQ;
  logic [5:0] wlEff;
  logic [7:0] cntQ;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  assign wlEff = (wlQ == 6'h00) ? 6'h01 : wlQ;
  // Shadow of latency; assumes full byte enables on that write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wlQ <= 6'h09;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h04) begin
      wlQ <= 6'(wb_dat_i[4:0]) + 6'(wb_dat_i[12:8]);
    end
  end
  // Armed only from an idle stream, overlapping bursts are not timed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cntQ <= 8'h00;
    end else if (cmdValid && cmdKind == CMD_WRITE && cntQ == 8'h00 && !coreValid) begin
      cntQ <= 8'(wlEff) + 8'h02;
    end else if (cntQ != 8'h00) begin
      cntQ <= cntQ - 8'h01;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered by one ack pulse");
  property p_unmapped;
    s_req ##0 (!wb_we_i && wb_adr_i > 8'h10) |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dat_hold;
    !wb_ack_o && !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without access");
  property p_first_word;
    cntQ == 8'h01 |=> coreValid;
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word late");
  property p_no_early;
    cntQ > 8'h01 |-> !coreValid;
  endproperty
  a_no_early: assert property (p_no_early) else $error("first word early");
  property p_hold;
    coreValid && !coreReady |=> coreValid && $stable(coreWord);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word not held");
endmodule : dwb_checker

bind dwb_write_engine dwb_checker #(.DQ_W(DQ_W), .COL_W(COL_W)) u_chk (
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cmdValid(cmdValid), .cmdKind(cmdKind), .coreValid(coreValid), .coreReady(coreReady),
  .coreWord(coreWord));

// [test/dwb_host_model.sv]
module dwb_host_model #(
  parameter int COL_W = 10,
  parameter int DQ_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  output logic cmdValid,
  output dwb_pkg::dwb_cmd_t cmdKind,
  output logic [1:0] cmdBankGroup,
  output logic [1:0] cmdBank,
  output logic [COL_W-1:0] cmdColumn,
  output logic chopSelectAddressBit,
  output logic autoprechargeAddressBit,
  output logic [2*DQ_W-1:0] writeData
);
  timeunit 1ns;
  timeprecision 100ps;
  import dwb_pkg::*;
  initial begin
    cmdValid = 1'b0;
    cmdKind = CMD_NOP;
    cmdBankGroup = 2'h0;
    cmdBank = 2'h0;
    cmdColumn = '0;
    chopSelectAddressBit = 1'b0;
    autoprechargeAddressBit = 1'b0;
  end
  // Data lines change every cycle, so a wrong capture edge shows
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      writeData <= '0;
    end else begin
      writeData <= writeData + 1'b1;
    end
  end
  // One command; s returns the data value seen at the command edge
  task automatic issue(input dwb_cmd_t k, input logic [1:0] g, input logic [1:0] b,
                       input logic [COL_W-1:0] c, input logic ch, input logic ap,
                       output logic [2*DQ_W-1:0] s);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdBankGroup <= g;
    cmdBank <= b;
    cmdColumn <= c;
    chopSelectAddressBit <= ch;
    autoprechargeAddressBit <= ap;
    @(posedge clock);
    s = writeData;
    cmdValid <= 1'b0;
    cmdKind <= CMD_NOP;
    cmdBankGroup <= ~g;
    cmdBank <= ~b;
    cmdColumn <= ~c;
    chopSelectAddressBit <= ~ch;
    autoprechargeAddressBit <= ~ap;
  endtask : issue
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
endmodule : dwb_host_model

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dwb_pkg::*;
  logic clock, rst, cyc, stb, we, ack, coreReady, dataReady, coreValid;
  logic cmdValid, chopBit, apBit;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, rd;
  dwb_cmd_t cmdKind;
  logic [1:0] bg, bk;
  logic [9:0] col;
  logic [15:0] wData, bankOpen, stamp;
  logic [29:0] coreWord;
  logic [29:0] got[$];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  dwb_write_engine u_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdBankGroup(bg), .cmdBank(bk),
    .cmdColumn(col), .chopSelectAddressBit(chopBit), .autoprechargeAddressBit(apBit),
    .writeData(wData), .dataReady(dataReady), .coreValid(coreValid),
    .coreReady(coreReady), .coreWord(coreWord), .bankOpen(bankOpen));
  dwb_host_model u_host (.clock(clock), .rst(rst), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdBankGroup(bg), .cmdBank(bk), .cmdColumn(col), .chopSelectAddressBit(chopBit),
    .autoprechargeAddressBit(apBit), .writeData(wData));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (!rst && coreValid === 1'b1 && coreReady) got.push_back(coreWord);
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chkw(input logic [29:0] g, input logic [29:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t word=%h exp=%h", $time, g, e);
    end
  endtask : chkw
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic flags(input logic [2:0] e);
    wb(1'b0, 8'h0C, 32'h0);
    chk({29'h0, rd[18:16]}, {29'h0, e});
  endtask : flags
  task automatic burst(input logic [1:0] mode, input logic chop, input int nw, input int wl);
    logic [15:0] s;
    wb(1'b1, 8'h00, {30'h0, mode});
    got.delete();
    u_host.issue(CMD_WRITE, 2'h1, 2'h1, 10'h040, chop, 1'b0, s);
    u_host.idle(wl + 14);
    chk(32'(got.size()), 32'(nw));
    for (int i = 0; i < got.size() && i < nw; i++) begin
      chkw(got[i], {4'h5, 10'h040 + 10'(2 * i), s + 16'(wl + i)});
    end
  endtask : burst
  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    datI = 32'h0;
    coreReady = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h04, 32'h0000_0900);
    rdchk(8'h08, 32'h0704_020C);
    rdchk(8'h20, 32'h0000_0000);
    sel <= 4'h1;
    wb(1'b1, 8'h08, 32'hAAAA_AA0D);
    sel <= 4'hF;
    rdchk(8'h08, 32'h0704_020D);
    $display("test reset values done");
    burst(2'h0, 1'b0, 4, 9);
    burst(2'h1, 1'b1, 4, 9);
    burst(2'h1, 1'b0, 2, 9);
    burst(2'h2, 1'b1, 2, 9);
    burst(2'h3, 1'b0, 4, 9);
    rdchk(8'h10, 32'h0000_0005);
    wb(1'b1, 8'h04, 32'h0000_0502);
    burst(2'h0, 1'b1, 4, 7);
    $display("test burst modes done");
    u_host.issue(CMD_ACT, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
    u_host.idle(4);
    chk({31'h0, bankOpen[11]}, 32'h1);
    u_host.issue(CMD_WRITE, 2'h2, 2'h3, 10'h0, 1'b1, 1'b1, stamp);
    u_host.idle(40);
    chk({31'h0, bankOpen[11]}, 32'h0);
    u_host.issue(CMD_ACT, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
    u_host.issue(CMD_WRITE, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
    u_host.idle(40);
    chk({31'h0, bankOpen[11]}, 32'h1);
    u_host.issue(CMD_PRE, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
    flags(3'h0);
    u_host.issue(CMD_ACT, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
    u_host.issue(CMD_WRITE, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
    u_host.issue(CMD_PRE, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
    flags(3'h2);
    wb(1'b1, 8'h0C, 32'h0007_0000);
    flags(3'h0);
    // Precharge exactly at recovery expiry, then one clock before it
    for (int i = 0; i < 2; i++) begin
      u_host.issue(CMD_ACT, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
      u_host.idle(10);
      u_host.issue(CMD_WRITE, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
      u_host.idle(22 - i);
      u_host.issue(CMD_PRE, 2'h2, 2'h3, 10'h0, 1'b1, 1'b0, stamp);
      flags(i == 0 ? 3'h0 : 3'h2);
      wb(1'b1, 8'h0C, 32'h0007_0000);
    end
    u_host.idle(30);
    $display("test bank close done");
    // Read lands between the short and the long write-to-read times
    for (int i = 0; i < 2; i++) begin
      u_host.issue(CMD_WRITE, 2'h1, 2'h0, 10'h0, 1'b1, 1'b0, stamp);
      u_host.idle(12);
      u_host.issue(CMD_READ, 2'(i + 1), 2'h1, 10'h0, 1'b1, 1'b0, stamp);
      flags(i == 0 ? 3'h1 : 3'h0);
      wb(1'b1, 8'h0C, 32'h0007_0000);
      u_host.idle(20);
    end
    $display("test write to read done");
    coreReady <= 1'b0;
    got.delete();
    for (int i = 0; i < 6; i++) begin
      u_host.issue(CMD_WRITE, 2'h0, 2'h0, 10'h0, 1'b1, 1'b0, stamp);
      u_host.idle(2);
    end
    u_host.idle(20);
    chk({31'h0, dataReady}, 32'h0);
    flags(3'h4);
    coreReady <= 1'b1;
    u_host.idle(40);
    chk(32'(got.size()), 32'd17);
    chk({31'h0, coreValid}, 32'h0);
    $display("test buffer fill done");
    report_and_stop();
  end
endmodule : tb
